// file: logic/watchdog_config_map.vh
// register offsets, field positions and reset values of the watchdog configuration block
`ifndef WATCHDOG_CONFIG_MAP_VH
`define WATCHDOG_CONFIG_MAP_VH

`define WDC_ADDR_W 24
`define WDC_OFS_MODE_PERIOD 24'h300004
`define WDC_OFS_CLOCK_WINDOW 24'h300005
`define WDC_OFS_RUNTIME_CONTROL 24'h300010
`define WDC_OFS_STATUS 24'h300011
`define WDC_OFS_CLEAR 24'h300012

`define WDC_MODE_HI 6
`define WDC_MODE_LO 5
`define WDC_PERIOD_HI 4
`define WDC_PERIOD_LO 0
`define WDC_CLKSRC_HI 5
`define WDC_CLKSRC_LO 3
`define WDC_WINDOW_HI 2
`define WDC_WINDOW_LO 0

`define WDC_MODE_ALWAYS 2'h3
`define WDC_MODE_AWAKE 2'h2
`define WDC_MODE_SOFTWARE 2'h1
`define WDC_MODE_OFF 2'h0

`define WDC_PERIOD_SOFT 5'h1f
`define WDC_PERIOD_SOFT_LOAD 5'h0b
`define WDC_PERIOD_MAX 5'h12
`define WDC_PRESCALE_BASE 5'h05
`define WDC_CLKSRC_SOFT 3'h7

`define WDC_RESET_MODE_PERIOD 8'h7f
`define WDC_RESET_CLOCK_WINDOW 8'h3f

// runtime control byte: bit 0 run enable, bits 5:1 runtime period
`define WDC_CTL_SEN 0
`define WDC_CTL_PER_HI 5
`define WDC_CTL_PER_LO 1
// status byte: bit 0 timeout, bit 1 running, bit 2 software clock select
`define WDC_STS_TIMEOUT 0
`define WDC_STS_RUNNING 1
`define WDC_STS_SOFTCLK 2

`define WDC_COUNT_W 28

`endif

// file: logic/watchdog_prescale_count.v
// prescaled watchdog counter with timeout pulse
`timescale 1ns/1ps
`include "watchdog_config_map.vh"

module watchdog_prescale_count (
  input wire clk_sys_i,
  input wire rst_i,
  input wire run_i,
  input wire clear_i,
  input wire tick_i,
  input wire [4:0] period_i,
  output reg expire_o
);

  reg [`WDC_COUNT_W-1:0] count;
  reg [4:0] shift;
  wire [`WDC_COUNT_W-1:0] limit;

  // codes above the top step fall back to 1:32
  always @*
  begin
    if (period_i > `WDC_PERIOD_MAX)
      shift = `WDC_PRESCALE_BASE;
    else
      shift = period_i + `WDC_PRESCALE_BASE;
  end

  assign limit = {{(`WDC_COUNT_W-1){1'b0}}, 1'b1} << shift;

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count <= {`WDC_COUNT_W{1'b0}};
      expire_o <= 1'b0;
    end
    else
    begin
      expire_o <= 1'b0;
      if (clear_i || !run_i)
        count <= {`WDC_COUNT_W{1'b0}};
      else if (tick_i)
      begin
        if (count + 1'b1 >= limit)
        begin
          count <= {`WDC_COUNT_W{1'b0}};
          expire_o <= 1'b1;
        end
        else
          count <= count + 1'b1;
      end
    end
  end

endmodule // watchdog_prescale_count

// file: logic/watchdog_config_decode.v
// watchdog configuration decode, runtime control and timeout
// Summary of operation
// - mode 11: watchdog runs awake and asleep, run enable ignored
// - mode 10: runs awake, count cleared during sleep, run enable ignored
// - mode 01: watchdog follows the software run enable bit
// - mode 00: watchdog always disabled
// - period code 11111 loads runtime period 01011, software may change it
// - prescale is 2^(code+5), codes 10011..11110 give 1:32
// - byte six: clock source bits 5:3, window bits 2:0, erase ones
// - byte five at 0x300004: mode bits 6:5, period bits 4:0
// - clock source unused when off; code 111 gives software clock choice
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "watchdog_config_map.vh"

module watchdog_config_decode (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [`WDC_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire sleep_i,
  input wire dog_clk_i,
  output reg [7:0] rdata_o,
  output reg timeout_o,
  output reg running_o,
  output reg soft_clock_select_o,
  output reg [1:0] dog_operating_mode_o,
  output reg [4:0] dog_runtime_period_o,
  output reg [2:0] dog_window_code_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [7:0] config_byte_five;
  reg [7:0] config_byte_six;
  reg software_run_enable;
  reg [4:0] dog_runtime_period;
  reg timeout_flag;
  reg sleep_s1;
  reg sleep_s2;
  reg clk_s1;
  reg clk_s2;
  reg clk_s3;
  reg next_run;
  wire [1:0] dog_operating_mode;
  wire [4:0] dog_period_code;
  wire [2:0] dog_clock_source_code;
  wire [2:0] dog_window_code;
  wire dog_tick;
  wire expire;
  wire soft_clock;
  wire clear_pulse;
  wire hit_mode_period;
  wire hit_clock_window;
  wire hit_runtime_control;
  wire hit_status;
  wire hit_clear;
  wire write_five;
  wire write_six;
  wire write_control;
  wire write_status;
  wire soft_period;
  wire [7:0] control_byte;
  wire [7:0] status_byte;
  reg [7:0] next_rdata;

  assign dog_operating_mode = config_byte_five[`WDC_MODE_HI:`WDC_MODE_LO];
  assign dog_period_code = config_byte_five[`WDC_PERIOD_HI:`WDC_PERIOD_LO];
  assign dog_clock_source_code = config_byte_six[`WDC_CLKSRC_HI:`WDC_CLKSRC_LO];
  assign dog_window_code = config_byte_six[`WDC_WINDOW_HI:`WDC_WINDOW_LO];
  assign soft_clock = (dog_operating_mode != `WDC_MODE_OFF) &&
    (dog_clock_source_code == `WDC_CLKSRC_SOFT);
  assign clear_pulse = wr_i && hit_clear;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign hit_mode_period = (addr_i == `WDC_OFS_MODE_PERIOD);
  assign hit_clock_window = (addr_i == `WDC_OFS_CLOCK_WINDOW);
  assign hit_runtime_control = (addr_i == `WDC_OFS_RUNTIME_CONTROL);
  assign hit_status = (addr_i == `WDC_OFS_STATUS);
  assign hit_clear = (addr_i == `WDC_OFS_CLEAR);
  assign write_five = wr_i && hit_mode_period;
  assign write_six = wr_i && hit_clock_window;
  assign write_control = wr_i && hit_runtime_control;
  assign write_status = wr_i && hit_status;
  // runtime period open to software only under the soft code
  assign soft_period = (dog_period_code == `WDC_PERIOD_SOFT);
  assign control_byte = {2'h0, dog_runtime_period, software_run_enable};
  assign status_byte = {5'h00, soft_clock, next_run, timeout_flag};

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // sleep level, two flops
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
    end
    else
    begin
      sleep_s1 <= sleep_i;
      sleep_s2 <= sleep_s1;
    end
  end

  // input clock, two flops and a third for the edge
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end
    else
    begin
      clk_s1 <= dog_clk_i;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  // ----------------------------------------------------------------
  // input clock edge
  // ----------------------------------------------------------------
  // flops reset low like the idle pin, so no false edge after reset
  assign dog_tick = clk_s2 && !clk_s3;

  // ----------------------------------------------------------------
  // operating mode decode
  // ----------------------------------------------------------------
  always @*
  begin
    case (dog_operating_mode)
      `WDC_MODE_ALWAYS: next_run = 1'b1;
      `WDC_MODE_AWAKE: next_run = !sleep_s2;
      `WDC_MODE_SOFTWARE: next_run = software_run_enable;
      `WDC_MODE_OFF: next_run = 1'b0;
      default: next_run = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // byte five: mode and period code, bit 7 reads zero
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      config_byte_five <= `WDC_RESET_MODE_PERIOD;
    else if (write_five)
      config_byte_five <= {1'b0, wdata_i[6:0]};
  end

  // byte six: clock source and window, bits 7:6 read zero
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      config_byte_six <= `WDC_RESET_CLOCK_WINDOW;
    else if (write_six)
      config_byte_six <= {2'h0, wdata_i[5:0]};
  end

  // software run enable, only heard in mode 01
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      software_run_enable <= 1'b0;
    else if (write_control)
      software_run_enable <= wdata_i[`WDC_CTL_SEN];
  end

  // runtime period: reset byte five holds the soft code, so load 01011
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      dog_runtime_period <= `WDC_PERIOD_SOFT_LOAD;
    else if (write_five)
    begin
      if (wdata_i[`WDC_PERIOD_HI:`WDC_PERIOD_LO] == `WDC_PERIOD_SOFT)
        dog_runtime_period <= `WDC_PERIOD_SOFT_LOAD;
      else
        dog_runtime_period <= wdata_i[`WDC_PERIOD_HI:`WDC_PERIOD_LO];
    end
    else if (write_control && soft_period)
      dog_runtime_period <= wdata_i[`WDC_CTL_PER_HI:`WDC_CTL_PER_LO];
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  watchdog_prescale_count u_count (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(next_run),
    .clear_i(clear_pulse),
    .tick_i(dog_tick),
    .period_i(dog_runtime_period),
    .expire_o(expire)
  );

  // ----------------------------------------------------------------
  // timeout flag
  // ----------------------------------------------------------------
  // expiry wins over a same-cycle clear
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      timeout_flag <= 1'b0;
    else if (expire)
      timeout_flag <= 1'b1;
    else if (write_status && wdata_i[`WDC_STS_TIMEOUT])
      timeout_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // unmapped addresses and idle cycles read zero
  always @*
  begin
    next_rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `WDC_OFS_MODE_PERIOD: next_rdata = config_byte_five;
        `WDC_OFS_CLOCK_WINDOW: next_rdata = config_byte_six;
        `WDC_OFS_RUNTIME_CONTROL: next_rdata = control_byte;
        `WDC_OFS_STATUS: next_rdata = status_byte;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // read data stand for one cycle, zero otherwise
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= next_rdata;
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // sticky until software writes a one to bit 0 of the status byte
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      timeout_o <= 1'b0;
    else
      timeout_o <= timeout_flag;
  end

  // follows the mode decode one cycle late
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      running_o <= 1'b0;
    else
      running_o <= next_run;
  end

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      soft_clock_select_o <= 1'b0;
    else
      soft_clock_select_o <= soft_clock;
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  // field copies for the clock and window users outside
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      dog_operating_mode_o <= 2'h0;
    else
      dog_operating_mode_o <= dog_operating_mode;
  end

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      dog_runtime_period_o <= 5'h00;
    else
      dog_runtime_period_o <= dog_runtime_period;
  end

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      dog_window_code_o <= 3'h0;
    else
      dog_window_code_o <= dog_window_code;
  end

endmodule // watchdog_config_decode

// file: dv/watchdog_config_decode_props.sv
// port checks of the watchdog configuration decode
`timescale 1ns/1ps
`include "watchdog_config_map.vh"
module watchdog_config_decode_props (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [`WDC_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire sleep_i,
  input wire dog_clk_i,
  input wire [7:0] rdata_o,
  input wire timeout_o,
  input wire running_o,
  input wire soft_clock_select_o,
  input wire [1:0] dog_operating_mode_o,
  input wire [4:0] dog_runtime_period_o,
  input wire [2:0] dog_window_code_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_five;
    wr_i && addr_i == `WDC_OFS_MODE_PERIOD;
  endsequence
  sequence s_wr_six;
    wr_i && addr_i == `WDC_OFS_CLOCK_WINDOW;
  endsequence
  a_mode_load: assert property (s_wr_five |-> ##2 dog_operating_mode_o == $past(wdata_i[6:5], 2))
    else $error("mode field not loaded");
  a_period_copy: assert property (s_wr_five ##0 wdata_i[4:0] != 5'h1f
    |-> ##2 dog_runtime_period_o == $past(wdata_i[4:0], 2))
    else $error("period code not copied");
  a_soft_load: assert property (s_wr_five ##0 wdata_i[4:0] == 5'h1f
    |-> ##2 dog_runtime_period_o == 5'h0b)
    else $error("soft period load wrong");
  a_window_load: assert property (s_wr_six |-> ##2 dog_window_code_o == $past(wdata_i[2:0], 2))
    else $error("window field not loaded");
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_off_stopped: assert property (dog_operating_mode_o == 2'h0 [*2] |-> !running_o)
    else $error("running while mode is off");
  a_sleep_holds: assert property ((dog_operating_mode_o == 2'h2 && sleep_i) [*5] |-> !running_o)
    else $error("running asleep in awake mode");
  a_timeout_fall: assert property ($fell(timeout_o)
    |-> $past(wr_i, 2) && $past(addr_i, 2) == `WDC_OFS_STATUS)
    else $error("timeout dropped without clear");
endmodule // watchdog_config_decode_props

// file: dv/watchdog_config_decode_tb.sv
// self-checking bench of the watchdog configuration decode
`timescale 1ns/1ps
`include "watchdog_config_map.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module watchdog_config_decode_tb;
  localparam logic [23:0] a5 = `WDC_OFS_MODE_PERIOD;
  localparam logic [23:0] a6 = `WDC_OFS_CLOCK_WINDOW;
  localparam logic [23:0] actl = `WDC_OFS_RUNTIME_CONTROL;
  logic clk_sys_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sleep_i = 0, dog_clk_i = 0;
  logic [23:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o;
  logic timeout_o, running_o, soft_clock_select_o;
  logic [1:0] dog_operating_mode_o;
  logic [4:0] dog_runtime_period_o;
  logic [2:0] dog_window_code_o;
  int n_errors = 0, num_checks = 0;
  // byte five, mode, period, running with run enable low
  logic [15:0] rows [4] = '{{8'h7f, 2'h3, 5'h0b, 1'b1}, {8'hd2, 2'h2, 5'h12, 1'b1},
    {8'h33, 2'h1, 5'h13, 1'b0}, {8'h00, 2'h0, 5'h00, 1'b0}};
  watchdog_config_decode watchdog_config_decode_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .sleep_i(sleep_i), .dog_clk_i(dog_clk_i),
    .rdata_o(rdata_o), .timeout_o(timeout_o), .running_o(running_o),
    .soft_clock_select_o(soft_clock_select_o), .dog_operating_mode_o(dog_operating_mode_o),
    .dog_runtime_period_o(dog_runtime_period_o), .dog_window_code_o(dog_window_code_o));
  initial
  begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task conclude;
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 0;
  endtask
  task rd(input logic [23:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 0;
    #1;
    `CHK("rdata", e, rdata_o)
  endtask
  task edges(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_sys_i);
      dog_clk_i <= 1;
      repeat (4) @(posedge clk_sys_i);
      dog_clk_i <= 0;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 0;
    wt(3);
    `CHK("period", 5'h0b, dog_runtime_period_o)
    `CHK("run", 1'b1, running_o)
    rd(a6, 8'h3f);
    for (int i = 0; i < 4; i++)
    begin
      wr(a5, rows[i][15:8]);
      wt(3);
      `CHK("mode", rows[i][7:6], dog_operating_mode_o)
      `CHK("period", rows[i][5:1], dog_runtime_period_o)
      `CHK("run", rows[i][0], running_o)
      rd(a5, rows[i][15:8] & 8'h7f);
    end
    wr(a5, 8'h25);
    wr(actl, 8'h0f);
    wt(3);
    `CHK("run", 1'b1, running_o)
    `CHK("period", 5'h05, dog_runtime_period_o)
    wr(actl, 8'h00);
    wt(3);
    `CHK("run", 1'b0, running_o)
    wr(a5, 8'h1f);
    wr(actl, 8'h01);
    wt(3);
    `CHK("run", 1'b0, running_o)
    `CHK("soft", 1'b0, soft_clock_select_o)
    wr(a5, 8'h7f);
    wr(actl, 8'h06);
    wt(3);
    `CHK("period", 5'h03, dog_runtime_period_o)
    `CHK("soft", 1'b1, soft_clock_select_o)
    wr(a6, 8'h2a);
    wt(3);
    `CHK("window", 3'h2, dog_window_code_o)
    `CHK("soft", 1'b0, soft_clock_select_o)
    wr(24'h300020, 8'hff);
    rd(24'h300020, 8'h00);
    wr(a5, 8'h40);
    sleep_i <= 1;
    wt(8);
    `CHK("run", 1'b0, running_o)
    wr(a5, 8'h60);
    wt(3);
    `CHK("run", 1'b1, running_o)
    wr(a5, 8'h40);
    sleep_i <= 0;
    wt(8);
    `CHK("run", 1'b1, running_o)
    // 32 input edges for code 0 and a fallback code
    for (int i = 0; i < 2; i++)
    begin
      wr(a5, i ? 8'h73 : 8'h60);
      wr(`WDC_OFS_CLEAR, 8'h00);
      wr(`WDC_OFS_STATUS, 8'h01);
      edges(31);
      wt(3);
      `CHK("timeout", 1'b0, timeout_o)
      edges(1);
      wt(8);
      `CHK("timeout", 1'b1, timeout_o)
    end
    // reset in mid-run brings back the erased configuration
    @(posedge clk_sys_i);
    rst_i <= 1;
    wt(2);
    `CHK("timeout", 1'b0, timeout_o)
    @(posedge clk_sys_i);
    rst_i <= 0;
    wt(3);
    `CHK("period", 5'h0b, dog_runtime_period_o)
    `CHK("run", 1'b1, running_o)
    rd(a5, 8'h7f);
    conclude;
  end
endmodule // watchdog_config_decode_tb
bind watchdog_config_decode watchdog_config_decode_props props_i (.*);
